// ==== pkg/bmc_phy_regs.svh ====
// Timing and line constants of the biphase mark line coder
`ifndef BMC_PHY_REGS_SVH
`define BMC_PHY_REGS_SVH

// System clock rate in MHz
`define BMC_CLK_MHZ 100
// Half of one unit interval in ns, nominal 300 kbit/s line rate
`define BMC_HALF_UI_NS 1667
// Half unit interval in clock cycles, rounded down
`define BMC_HALF_UI_CYC ((`BMC_HALF_UI_NS * `BMC_CLK_MHZ) / 1000)
// Edge closer than NUM/DEN half intervals after a boundary is a mid-cell edge
`define BMC_MID_LIMIT_NUM 3
`define BMC_MID_LIMIT_DEN 2
// Half intervals of silence that end a received frame
`define BMC_RX_TIMEOUT_HALVES 4
// Smallest half interval the logic can serve
`define BMC_MIN_HALF_CYC 4
// Line select codes
`define BMC_SEL_LINE_A 1'h0
`define BMC_SEL_LINE_B 1'h1
// Line level while nobody drives, held up by the attach bias
`define BMC_LINE_IDLE 1'h1

`endif

// ==== pkg/bmc_pkg.sv ====
// Types of the biphase mark line coder
`default_nettype none
package bmc_pkg;

  typedef enum logic [2:0] {
    BMC_IDLE = 3'h0,
    BMC_LEAD = 3'h1,
    BMC_FIRST = 3'h2,
    BMC_SECOND = 3'h3,
    BMC_CLOSE = 3'h4
  } bmc_tx_state_t;

endpackage : bmc_pkg
`default_nettype wire

// ==== logic/bmc_rx_dec.sv ====
// Biphase mark decoder recovering bits from line edges
`include "bmc_phy_regs.svh"
`default_nettype none
module bmc_rx_dec #(
  parameter int HALF_UI_CYC = `BMC_HALF_UI_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Line
  input wire logic enable_i,
  input wire logic line_i,
  // Decoded bits
  output logic rx_bit_o,
  output logic rx_valid_o,
  output logic rx_busy_o
);

  localparam int MID_LIM = (HALF_UI_CYC * `BMC_MID_LIMIT_NUM) / `BMC_MID_LIMIT_DEN;
  localparam int TMO = HALF_UI_CYC * `BMC_RX_TIMEOUT_HALVES;
  localparam int CW = $clog2(TMO + 1);

  logic line_r;
  logic edge_w;
  logic busy_r;
  logic mid_r;
  logic [CW-1:0] cnt_r;

  assign edge_w = enable_i && (line_i != line_r);
  assign rx_busy_o = busy_r;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // Idle level avoids a false edge after reset
      line_r <= `BMC_LINE_IDLE;
    end else begin
      line_r <= line_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_r <= 1'h0;
      cnt_r <= '0;
      mid_r <= 1'h0;
      rx_bit_o <= 1'h0;
      rx_valid_o <= 1'h0;
    end else begin
      rx_valid_o <= 1'h0;
      if (!enable_i) begin
        busy_r <= 1'h0;
        mid_r <= 1'h0;
      end else if (edge_w) begin
        if (busy_r && (cnt_r < CW'(MID_LIM))) begin
          mid_r <= 1'h1;
        end else begin
          rx_bit_o <= mid_r;
          rx_valid_o <= busy_r;
          busy_r <= 1'h1;
          mid_r <= 1'h0;
          cnt_r <= '0;
        end
      end else if (busy_r) begin
        if (cnt_r >= CW'(TMO)) begin
          busy_r <= 1'h0;
          mid_r <= 1'h0;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  bit_on_edge_a: assert property (rx_valid_o |-> $past(edge_w) && $past(busy_r))
    else $error("decoded bit without a boundary edge");
  bit_value_a: assert property ((edge_w && busy_r && cnt_r >= CW'(MID_LIM))
      |=> rx_valid_o && rx_bit_o == $past(mid_r))
    else $error("decoded bit value wrong");

endmodule : bmc_rx_dec
`default_nettype wire

// ==== logic/bmc_phy.sv ====
// Biphase mark transmitter and receiver for the configuration line pair
// How it works
// - Toggle line at every cell start.
// - Ones toggle mid-cell; zeros hold level.
// - Preamble starts by driving low level.
// - Closing edge ends final end-of-packet bit.
// - Driver enabled only while sending message.
// - Use only line chosen by orientation.
// - One driver at a time; else high impedance.
// - Coding every cell bounds DC disparity.
`include "bmc_phy_regs.svh"
`default_nettype none
module bmc_phy #(
  parameter int HALF_UI_CYC = `BMC_HALF_UI_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Cable orientation
  input wire logic config_line_sel_i,
  // Transmit bit stream
  input wire logic tx_valid_i,
  input wire logic tx_data_i,
  input wire logic tx_last_i,
  output logic tx_ready_o,
  output logic tx_busy_o,
  // Receive bit stream
  output logic rx_bit_o,
  output logic rx_valid_o,
  output logic rx_busy_o,
  // Configuration line a
  input wire logic config_line_a_i,
  output logic config_line_a_o,
  output logic config_line_a_oe_o,
  // Configuration line b
  input wire logic config_line_b_i,
  output logic config_line_b_o,
  output logic config_line_b_oe_o
);

  localparam int CW = $clog2(HALF_UI_CYC);

  if (HALF_UI_CYC < `BMC_MIN_HALF_CYC) begin : g_bad_half
    $error("HALF_UI_CYC too small");
  end

  bmc_pkg::bmc_tx_state_t st_r;
  logic [CW-1:0] cnt_r;
  logic tick_w;
  logic lvl_r;
  logic bit_r;
  logic last_r;
  logic sel_r;
  logic drive_w;
  logic boundary_w;
  logic take_w;
  logic rx_line_w;

  function automatic logic pick_line(input logic sel, input logic a, input logic b);
    pick_line = (sel == `BMC_SEL_LINE_B) ? b : a;
  endfunction : pick_line

  // Half interval divider, restarted at frame start
  assign tick_w = (st_r != bmc_pkg::BMC_IDLE) && (cnt_r == '0);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= '0;
    end else if (st_r == bmc_pkg::BMC_IDLE || tick_w) begin
      cnt_r <= CW'(HALF_UI_CYC - 1);
    end else begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign boundary_w = tick_w && (st_r == bmc_pkg::BMC_LEAD || (st_r == bmc_pkg::BMC_SECOND && !last_r));
  assign tx_ready_o = boundary_w;
  assign take_w = boundary_w && tx_valid_i;
  assign tx_busy_o = drive_w;

  // Transmit sequencer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= bmc_pkg::BMC_IDLE;
    end else begin
      unique case (st_r)
        bmc_pkg::BMC_IDLE: begin
          if (tx_valid_i) begin
            st_r <= bmc_pkg::BMC_LEAD;
          end
        end
        bmc_pkg::BMC_LEAD: begin
          if (tick_w) begin
            st_r <= tx_valid_i ? bmc_pkg::BMC_FIRST : bmc_pkg::BMC_CLOSE;
          end
        end
        bmc_pkg::BMC_FIRST: begin
          if (tick_w) begin
            st_r <= bmc_pkg::BMC_SECOND;
          end
        end
        bmc_pkg::BMC_SECOND: begin
          if (tick_w) begin
            st_r <= (take_w) ? bmc_pkg::BMC_FIRST : bmc_pkg::BMC_CLOSE;
          end
        end
        bmc_pkg::BMC_CLOSE: begin
          if (tick_w) begin
            st_r <= bmc_pkg::BMC_IDLE;
          end
        end
        default: begin
          st_r <= bmc_pkg::BMC_IDLE;
        end
      endcase
    end
  end

  // Bit being sent and its end-of-frame mark
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bit_r <= 1'h0;
      last_r <= 1'h0;
    end else if (st_r == bmc_pkg::BMC_IDLE) begin
      last_r <= 1'h0;
    end else if (take_w) begin
      bit_r <= tx_data_i;
      last_r <= tx_last_i;
    end
  end

  // Line level
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lvl_r <= 1'h0;
    end else if (st_r == bmc_pkg::BMC_IDLE) begin
      lvl_r <= 1'h0;
    end else if (tick_w) begin
      if (st_r == bmc_pkg::BMC_FIRST) begin
        lvl_r <= lvl_r ^ bit_r;
      end else if (st_r == bmc_pkg::BMC_LEAD || st_r == bmc_pkg::BMC_SECOND) begin
        lvl_r <= ~lvl_r;
      end
    end
  end

  // Orientation frozen while a frame is being sent
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_r <= `BMC_SEL_LINE_A;
    end else if (st_r == bmc_pkg::BMC_IDLE) begin
      sel_r <= config_line_sel_i;
    end
  end

  assign drive_w = (st_r != bmc_pkg::BMC_IDLE);
  assign config_line_a_oe_o = drive_w && (sel_r == `BMC_SEL_LINE_A);
  assign config_line_b_oe_o = drive_w && (sel_r == `BMC_SEL_LINE_B);
  assign config_line_a_o = lvl_r;
  assign config_line_b_o = lvl_r;

  assign rx_line_w = pick_line(sel_r, config_line_a_i, config_line_b_i);

  // decoder starts a cell at an edge unless it comes less than MID_LIM cycles after the last boundary
  bmc_rx_dec #(
    .HALF_UI_CYC(HALF_UI_CYC)
  ) u_dec (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .enable_i(!drive_w),
    .line_i(rx_line_w),
    .rx_bit_o(rx_bit_o),
    .rx_valid_o(rx_valid_o),
    .rx_busy_o(rx_busy_o)
  );

  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence start_s;
    st_r == bmc_pkg::BMC_IDLE && tx_valid_i;
  endsequence

  sequence one_mid_s;
    st_r == bmc_pkg::BMC_FIRST && tick_w && bit_r;
  endsequence

  lead_low_a: assert property (start_s |=> st_r == bmc_pkg::BMC_LEAD && !lvl_r && drive_w)
    else $error("preamble did not start low");
  cell_edge_a: assert property (take_w |=> lvl_r != $past(lvl_r))
    else $error("no edge at cell start");
  mid_one_a: assert property (one_mid_s |=> lvl_r != $past(lvl_r))
    else $error("one without mid-cell edge");
  mid_zero_a: assert property ((st_r == bmc_pkg::BMC_FIRST && !bit_r) |=> $stable(lvl_r))
    else $error("zero with mid-cell edge");
  close_edge_a: assert property ((st_r == bmc_pkg::BMC_SECOND && tick_w && last_r)
      |=> st_r == bmc_pkg::BMC_CLOSE && lvl_r != $past(lvl_r))
    else $error("final bit not closed by an edge");
  stop_early_a: assert property ((boundary_w && !tx_valid_i)
      |=> st_r == bmc_pkg::BMC_CLOSE && lvl_r != $past(lvl_r))
    else $error("frame not closed when bits ran out");
  lead_len_a: assert property (start_s |-> ##HALF_UI_CYC tx_ready_o)
    else $error("lead-in low half has wrong length");
  idle_hiz_a: assert property ((st_r == bmc_pkg::BMC_CLOSE && tick_w)
      |=> !config_line_a_oe_o && !config_line_b_oe_o)
    else $error("driver left on after frame");
  one_line_a: assert property (!(config_line_a_oe_o && config_line_b_oe_o))
    else $error("both lines driven");
  sel_hold_a: assert property ((drive_w && $past(drive_w)) |-> $stable(sel_r))
    else $error("line choice changed in a frame");
  half_cell_a: assert property ($changed(lvl_r) && drive_w && $past(drive_w)
      |-> $past(tick_w))
    else $error("level changed off the half-cell grid");

endmodule : bmc_phy
`default_nettype wire

// ==== test/bmc_far_end.sv ====
// Far-end party model sending biphase mark frames
`default_nettype none
module bmc_far_end #(
  parameter int HALF_UI_CYC = 8
) (
  // Clock
  input wire logic clk_i,
  // Line drive
  output logic line_o,
  output logic line_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    line_o = 1'b0;
    line_oe_o = 1'b0;
  end
  // Sends n bits lowest first
  task automatic send(input logic [15:0] bits, input int n, input bit drop);
    int i;
    @(posedge clk_i);
    #1;
    line_o = 1'b0;
    // low lead-in, or lost first edge
    if (!drop) begin
      line_oe_o = 1'b1;
      repeat (HALF_UI_CYC) @(posedge clk_i);
      #1;
    end
    for (i = 0; i < n; i++) begin
      line_o = ~line_o;
      line_oe_o = 1'b1;
      repeat (HALF_UI_CYC) @(posedge clk_i);
      #1;
      if (bits[i]) begin
        line_o = ~line_o;
      end
      repeat (HALF_UI_CYC) @(posedge clk_i);
      #1;
    end
    line_o = ~line_o;
    repeat (HALF_UI_CYC) @(posedge clk_i);
    #1;
    line_oe_o = 1'b0;
  endtask : send
endmodule : bmc_far_end
`default_nettype wire

// ==== test/bmc_phy_tb_top.sv ====
// Testbench of the biphase mark line coder
`default_nettype none
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %b got %b", nm, e, a); end end
module bmc_phy_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int H = 8;
  int checks = 0;
  int fail_count = 0;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic sel = 1'b0;
  logic tx_valid = 1'b0;
  logic tx_data = 1'b0;
  logic tx_last = 1'b0;
  logic tx_ready, tx_busy, rx_bit, rx_valid, rx_busy;
  logic a_o, a_oe, b_o, b_oe, far_d, far_oe, wire_a, wire_b, cur;
  logic rxq[$];
  assign wire_a = a_oe ? a_o : (far_oe ? far_d : 1'b1);
  assign wire_b = b_oe ? b_o : 1'b1;
  assign cur = sel ? b_o : a_o;
  bmc_phy #(.HALF_UI_CYC(H)) i_bmc_phy (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .config_line_sel_i(sel), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_last_i(tx_last),
    .tx_ready_o(tx_ready), .tx_busy_o(tx_busy), .rx_bit_o(rx_bit), .rx_valid_o(rx_valid),
    .rx_busy_o(rx_busy), .config_line_a_i(wire_a), .config_line_a_o(a_o), .config_line_a_oe_o(a_oe),
    .config_line_b_i(wire_b), .config_line_b_o(b_o), .config_line_b_oe_o(b_oe));
  bmc_far_end #(.HALF_UI_CYC(H)) i_bmc_far_end (.clk_i(clk_i), .line_o(far_d), .line_oe_o(far_oe));
  always #5 clk_i = ~clk_i;
  always @(negedge clk_i) begin
    if (rx_valid === 1'b1) begin
      rxq.push_back(rx_bit);
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic wait_ready();
    int k;
    k = 0;
    while (tx_ready !== 1'b1 && k < 4 * H) begin
      tick(1);
      k++;
    end
  endtask : wait_ready
  task automatic tx_frame(input logic s, input logic [3:0] bits);
    int i;
    int k;
    logic lvl;
    tick(1);
    sel = s;
    tx_valid = 1'b1;
    tx_data = bits[0];
    tick(2);
    `CHK("lead", 1'b0, cur)
    `CHK("oe on", 1'b1, s ? b_oe : a_oe)
    `CHK("oe other", 1'b0, s ? a_oe : b_oe)
    `CHK("rx off", 1'b0, rx_busy)
    for (i = 0; i < 4; i++) begin
      wait_ready();
      `CHK("ready", 1'b1, tx_ready)
      lvl = cur;
      tick(1);
      tx_data = bits[(i + 1) % 4];
      // Line b frame ends by dropping valid instead of marking last
      tx_last = (i == 2) && !s;
      tx_valid = (i != 3);
      tick(H / 2);
      `CHK("start", ~lvl, cur)
      tick(H);
      `CHK("mid", bits[i] ? lvl : ~lvl, cur)
    end
    tick(H);
    `CHK("close", bits[3] ? ~lvl : lvl, cur)
    `CHK("oe held", 1'b1, s ? b_oe : a_oe)
    k = 0;
    while (tx_busy !== 1'b0 && k < 4 * H) begin
      tick(1);
      k++;
    end
    tx_last = 1'b0;
    `CHK("oe off", 1'b0, a_oe | b_oe)
  endtask : tx_frame
  task automatic reset_mid();
    tick(1);
    tx_valid = 1'b1;
    tick(4);
    `CHK("mid oe", 1'b1, a_oe | b_oe)
    reset_n_i = 1'b0;
    tx_valid = 1'b0;
    tick(1);
    `CHK("rst oe", 1'b0, a_oe | b_oe)
    tick(2);
    reset_n_i = 1'b1;
    tick(2);
    `CHK("rst oe after", 1'b0, a_oe | b_oe)
    `CHK("rst busy", 1'b0, tx_busy)
  endtask : reset_mid
  task automatic rx_frame(input bit drop);
    logic [3:0] tl;
    tl = 4'h3;
    rxq.delete();
    sel = 1'b0;
    i_bmc_far_end.send(16'h03aa, 12, drop);
    tick(2);
    `CHK("oe idle", 1'b0, a_oe | b_oe)
    `CHK("count", 1'b1, rxq.size() >= 4)
    for (int j = 0; j < 4; j++) begin
      `CHK("rx bit", tl[j], rxq[rxq.size() - 4 + j])
    end
    `CHK("rx locked", 1'b1, rx_busy)
    tick(4 * H);
    `CHK("rx unlock", 1'b0, rx_busy)
  endtask : rx_frame
  task automatic print_verdict();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  initial begin
    tick(3);
    reset_n_i = 1'b1;
    `CHK("reset oe", 1'b0, a_oe | b_oe)
    tx_frame(1'b0, 4'b1101);
    tx_frame(1'b1, 4'b0110);
    reset_mid();
    rx_frame(1'b0);
    rx_frame(1'b1);
    print_verdict();
  end
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
endmodule : bmc_phy_tb_top
`default_nettype wire
